// ### rtl/fsc_bus_cycle.sv
`timescale 1ns/1ps
// single asynchronous read or write cycle on the flash pins
module fsc_bus_cycle
  import fsc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n_s,
  input  wire logic        ce_in,
  input  wire logic        start,
  input  fsc_cyc_s         req,
  input  wire logic [7:0]  dq_sync,
  output logic             done,
  output logic [7:0]       rdata,
  output logic [19:0]      addr_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_n,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n
);

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_ACT  = 2'b01,
    CY_HOLD = 2'b10
  } fsc_cy_e;

  fsc_cy_e            st_r, st_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  logic               wr_r, wr_nxt;
  logic [7:0]         rd_r, rd_nxt;
  logic [19:0]        a_r, a_nxt;
  logic [7:0]         d_r, d_nxt;
  logic               done_r, done_nxt;

  ////////////////////////////////////////////////////////////////////
  // strobe sequencing; read data sampled from synchronised pins,
  // so the active phase is stretched to cover the 2-flop delay
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_nxt   = wr_r;
    rd_nxt   = rd_r;
    a_nxt    = a_r;
    d_nxt    = d_r;
    done_nxt = 1'b0;
    unique case (st_r)
      CY_IDLE: begin
        if (start) begin
          st_nxt  = CY_ACT;
          wr_nxt  = req.wr;
          a_nxt   = req.addr;
          d_nxt   = req.data;
          cnt_nxt = req.wr ? CNT_W'(WP_CYC) : CNT_W'(RD_CYC + 2);
        end
      end
      CY_ACT: begin
        if (cnt_r > CNT_W'(1)) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          st_nxt  = CY_HOLD;
          rd_nxt  = dq_sync;
          cnt_nxt = CNT_W'(WPH_CYC > OEH_CYC ? WPH_CYC : OEH_CYC);
        end
      end
      CY_HOLD: begin
        if (cnt_r > CNT_W'(1)) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          st_nxt   = CY_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: st_nxt = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_r   <= CY_IDLE;
      cnt_r  <= '0;
      wr_r   <= 1'b0;
      rd_r   <= 8'h00;
      a_r    <= 20'h00000;
      d_r    <= 8'h00;
      done_r <= 1'b0;
    end else if (ce_in) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      a_r    <= a_nxt;
      d_r    <= d_nxt;
      done_r <= done_nxt;
    end
  end

  // every read completes with both strobes high, so the toggle bits
  // advance once per cycle whichever strobe the flash watches
  assign ce_n    = (st_r != CY_ACT);
  assign oe_n    = !(st_r == CY_ACT && !wr_r);
  assign we_n    = !(st_r == CY_ACT && wr_r);
  assign dq_oe_n = !(st_r != CY_IDLE && wr_r);
  assign dq_o    = d_r;
  assign addr_o  = a_r;
  assign rdata   = rd_r;
  assign done    = done_r;

endmodule // fsc_bus_cycle

// ### rtl/fsc_host.sv
`timescale 1ns/1ps
module fsc_host
  import fsc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata,
  output logic [19:0]      fl_addr,
  input  wire logic [7:0]  fl_dq_i,
  output logic [7:0]       fl_dq_o,
  output logic             fl_dq_oe_n,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  input  wire logic        ready_busy_out
);

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_CYC   = 3'b001,
    HS_POLL1 = 3'b010,
    HS_POLL2 = 3'b011,
    HS_RECHK = 3'b100,
    HS_RST   = 3'b101,
    HS_ECHK  = 3'b110
  } fsc_hs_e;

  ////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic       rst_m_r, rst_s_r;
  logic [7:0] dq_m_r, dq_s_r;
  logic       rb_m_r, rb_s_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      dq_m_r <= 8'h00;
      dq_s_r <= 8'h00;
      rb_m_r <= 1'b1;
      rb_s_r <= 1'b1;
    end else if (clk_en) begin
      dq_m_r <= fl_dq_i;
      dq_s_r <= dq_m_r;
      rb_m_r <= ready_busy_out;
      rb_s_r <= rb_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // toggle compare used by the POLL2 and RECHK steps of the polling walk
  function automatic logic toggling(input logic [7:0] a,
                                    input logic [7:0] b);
    toggling = a[BIT_ALG_TOG] != b[BIT_ALG_TOG];
  endfunction

  fsc_hs_e     st_r, st_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0]  wdat_r, wdat_nxt;
  logic [7:0]  rdat_r, rdat_nxt;
  logic [7:0]  first_r, first_nxt;
  logic [7:0]  status_r, status_nxt;
  logic        ers_pre_r, ers_pre_nxt;
  logic        cyc_start;
  fsc_cyc_s    cyc_req;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic        ctl_hit;

  assign ctl_hit = sw_wr && sw_addr == REG_CTRL && st_r == HS_IDLE;

  ////////////////////////////////////////////////////////////////////
  // command sequencer and toggle polling walk
  always_comb begin
    st_nxt      = st_r;
    addr_nxt    = addr_r;
    wdat_nxt    = wdat_r;
    rdat_nxt    = rdat_r;
    first_nxt   = first_r;
    status_nxt  = status_r;
    ers_pre_nxt = ers_pre_r;
    cyc_start   = 1'b0;
    cyc_req     = '{wr: 1'b0, addr: addr_r, data: wdat_r};
    if (sw_wr && sw_addr == REG_ADDR && st_r == HS_IDLE) begin
      addr_nxt = sw_wdata[19:0];
    end
    if (sw_wr && sw_addr == REG_WDATA && st_r == HS_IDLE) begin
      wdat_nxt = sw_wdata[7:0];
    end
    // commands while busy are refused and flagged
    if (sw_wr && sw_addr == REG_CTRL && st_r != HS_IDLE) begin
      status_nxt[ST_REJECT] = 1'b1;
    end
    unique case (st_r)
      HS_IDLE: begin
        if (ctl_hit) begin
          status_nxt[ST_DONE]   = 1'b0;
          status_nxt[ST_FAIL]   = 1'b0;
          status_nxt[ST_REJECT] = 1'b0;
          if (sw_wdata[CTRL_RESET]) begin
            st_nxt = HS_RST;
          end else if (sw_wdata[CTRL_POLL]) begin
            st_nxt = HS_POLL1;
          end else if (sw_wdata[CTRL_ERS_CHECK]) begin
            st_nxt = HS_ECHK;
          end else if (sw_wdata[CTRL_WRITE] || sw_wdata[CTRL_READ]) begin
            st_nxt = HS_CYC;
          end
          if (st_nxt != HS_IDLE) begin
            cyc_start = 1'b1;
            cyc_req.wr = sw_wdata[CTRL_RESET] || (sw_wdata[CTRL_WRITE] &&
              !sw_wdata[CTRL_POLL] && !sw_wdata[CTRL_ERS_CHECK]);
            if (sw_wdata[CTRL_RESET]) begin
              cyc_req.addr = CMD_RESET_ADDR;
              cyc_req.data = CMD_RESET_DATA;
            end
          end
        end
      end
      // plain read or command write; idle reads give array data
      HS_CYC: begin
        if (cyc_done) begin
          rdat_nxt = cyc_rdata;
          status_nxt[ST_DONE] = 1'b1;
          st_nxt = HS_IDLE;
        end
      end
      // first read of the pair; address from REG_ADDR stays valid
      // valid polling address
      HS_POLL1: begin
        if (cyc_done) begin
          first_nxt = cyc_rdata;
          cyc_start = 1'b1;
          st_nxt    = HS_POLL2;
        end
      end
      HS_POLL2: begin
        if (cyc_done) begin
          rdat_nxt = cyc_rdata;
          status_nxt[ST_SUSP] = cyc_rdata[BIT_SECT_TOG] !=
                                first_r[BIT_SECT_TOG];
          if (!toggling(first_r, cyc_rdata)) begin
            status_nxt[ST_DONE] = 1'b1;
            st_nxt = HS_IDLE;
          end else if (cyc_rdata[BIT_TIME_LIMIT]) begin
            first_nxt = cyc_rdata;
            cyc_start = 1'b1;
            st_nxt    = HS_RECHK;
          end else begin
            first_nxt = cyc_rdata;
            cyc_start = 1'b1;
          end
        end
      end
      HS_RECHK: begin
        if (cyc_done) begin
          rdat_nxt = cyc_rdata;
          if (!toggling(first_r, cyc_rdata)) begin
            status_nxt[ST_DONE] = 1'b1;
            st_nxt = HS_IDLE;
          end else begin
            status_nxt[ST_FAIL] = 1'b1;
            cyc_start = 1'b1;
            cyc_req   = '{wr: 1'b1, addr: CMD_RESET_ADDR,
                          data: CMD_RESET_DATA};
            st_nxt    = HS_RST;
          end
        end
      end
      HS_RST: begin
        if (cyc_done) begin
          status_nxt[ST_DONE] = 1'b1;
          st_nxt = HS_IDLE;
        end
      end
      // bit 3 is read back, never assumed from timing
      HS_ECHK: begin
        if (cyc_done) begin
          rdat_nxt = cyc_rdata;
          if (ers_pre_r == 1'b0 && cyc_rdata[BIT_ERS_TIMER]) begin
            status_nxt[ST_REJECT] = 1'b1;
          end
          ers_pre_nxt = cyc_rdata[BIT_ERS_TIMER];
          status_nxt[ST_ERS_TIMER] = cyc_rdata[BIT_ERS_TIMER];
          status_nxt[ST_DONE] = 1'b1;
          st_nxt = HS_IDLE;
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
    status_nxt[ST_BUSY]  = (st_nxt != HS_IDLE);
    status_nxt[ST_READY] = rb_s_r;
  end

  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      st_r      <= HS_IDLE;
      addr_r    <= 20'h00000;
      wdat_r    <= 8'h00;
      rdat_r    <= 8'h00;
      first_r   <= 8'h00;
      status_r  <= 8'h00;
      ers_pre_r <= 1'b0;
    end else if (clk_en) begin
      st_r      <= st_nxt;
      addr_r    <= addr_nxt;
      wdat_r    <= wdat_nxt;
      rdat_r    <= rdat_nxt;
      first_r   <= first_nxt;
      status_r  <= status_nxt;
      ers_pre_r <= ers_pre_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe
  logic [31:0] rd_r, rd_nxt;

  always_comb begin
    rd_nxt = 32'h00000000;
    if (sw_rd) begin
      unique case (sw_addr)
        REG_ADDR:   rd_nxt = {12'h000, addr_r};
        REG_WDATA:  rd_nxt = {24'h000000, wdat_r};
        REG_STATUS: rd_nxt = {24'h000000, status_r};
        REG_RDATA:  rd_nxt = {24'h000000, rdat_r};
        default:    rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_r) begin
    if (!rst_s_r) begin
      rd_r <= 32'h00000000;
    end else if (clk_en) begin
      rd_r <= rd_nxt;
    end
  end

  assign sw_rdata = rd_r;

  ////////////////////////////////////////////////////////////////////
  // pin engine; each read is fully delimited by chip and output enable
  // strobed read cycles
  fsc_bus_cycle u_cyc (
    .clk_sys (clk_sys),
    .rst_n_s (rst_s_r),
    .ce_in   (clk_en),
    .start   (cyc_start),
    .req     (cyc_req),
    .dq_sync (dq_s_r),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .addr_o  (fl_addr),
    .dq_o    (fl_dq_o),
    .dq_oe_n (fl_dq_oe_n),
    .ce_n    (fl_ce_n),
    .oe_n    (fl_oe_n),
    .we_n    (fl_we_n)
  );

endmodule // fsc_host

// ### rtl/fsc_pkg.sv
package fsc_pkg;

  // bus cycle timing at 200 MHz (5 ns period)
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  // read cycle minimum, ns
  localparam int unsigned T_RC_NS        = 70;
  localparam int unsigned RD_CYC         =
    (T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write pulse width minimum, ns
  localparam int unsigned T_WP_NS        = 35;
  localparam int unsigned WP_CYC         =
    (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write pulse high minimum, ns
  localparam int unsigned T_WPH_NS       = 20;
  localparam int unsigned WPH_CYC        =
    (T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // output enable hold for toggle polling, ns
  localparam int unsigned T_OEH_NS       = 10;
  localparam int unsigned OEH_CYC        =
    (T_OEH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W          = 8;

  // status bit positions on the flash data bus
  localparam int unsigned BIT_SECT_TOG   = 2;
  localparam int unsigned BIT_ERS_TIMER  = 3;
  localparam int unsigned BIT_TIME_LIMIT = 5;
  localparam int unsigned BIT_ALG_TOG    = 6;
  localparam int unsigned BIT_POLL       = 7;

  // software register offsets
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_ADDR        = 4'h1;
  localparam logic [3:0] REG_WDATA       = 4'h2;
  localparam logic [3:0] REG_STATUS      = 4'h3;
  localparam logic [3:0] REG_RDATA       = 4'h4;
  // control register bits
  localparam int unsigned CTRL_READ      = 0;
  localparam int unsigned CTRL_WRITE     = 1;
  localparam int unsigned CTRL_POLL      = 2;
  localparam int unsigned CTRL_RESET     = 3;
  localparam int unsigned CTRL_ERS_CHECK = 4;
  // status register bits
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_DONE        = 1;
  localparam int unsigned ST_FAIL        = 2;
  localparam int unsigned ST_REJECT      = 3;
  localparam int unsigned ST_ERS_TIMER   = 4;
  localparam int unsigned ST_READY       = 5;
  localparam int unsigned ST_SUSP        = 6;

  // reset command byte and its address
  localparam logic [7:0]  CMD_RESET_DATA = 8'hf0;
  localparam logic [19:0] CMD_RESET_ADDR = 20'h00000;

  // one bus cycle request toward the pin engine
  typedef struct packed {
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  data;
  } fsc_cyc_s;

endpackage

// ### test/fsc_flash_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// behavioural flash: status bits during a loaded algorithm, array otherwise
module fsc_flash_model
  import fsc_pkg::*;
(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dq_h,
  input  wire logic        dq_oe_n,
  input  wire logic        load,
  input  wire logic [7:0]  ld_reads,
  input  wire logic        ld_fail,
  input  wire logic        ld_sect,
  input  wire logic        ld_timer,
  input  wire logic        ld_susp,
  output logic [7:0]       dq_i,
  output logic             ready_busy_out,
  output int               rst_cmds
);
  logic       busy = 1'b0, fail = 1'b0, sect = 1'b0, timer = 1'b0;
  logic       susp = 1'b0;
  logic       tog6 = 1'b0, tog2 = 1'b0;
  logic [7:0] left = 8'h00, last = 8'h00, wd = 8'h00, drv;
  wire        rd_w = !ce_n && !oe_n;
  wire        wr_w = !ce_n && !we_n;
  wire        in_sect = addr[16]; // the model's one erase sector
  initial rst_cmds = 0;

  // erase datum is all ones, so bit 7 shows its complement
  // suspended: status only inside the suspended sector
  always_comb begin
    if (busy && !susp) begin
      drv = {1'b0, tog6, fail, 1'b0, timer, sect & tog2, 2'b00};
    end else if (busy && in_sect) begin
      drv = {1'b1, tog6, 1'b0, 1'b0, 1'b0, tog2, 2'b00};
    end else begin
      drv = addr[7:0] ^ 8'h5a;
    end
  end
  // released bus shows the inverse of the last byte: no pull-up here
  assign dq_i = !dq_oe_n ? dq_h : (rd_w ? drv : ~last);
  // busy pin low only while the algorithm runs
  assign ready_busy_out = !busy || susp;
  // valid at once, reload restarts window
  always @(posedge load) begin
    busy = 1'b1;
    left = ld_reads;
    fail = ld_fail;
    sect = ld_sect;
    timer = ld_timer;
    susp = ld_susp;
  end
  // advance per read, fail never ends
  always @(negedge rd_w) begin
    last = drv;
    if (busy && !susp) begin
      tog6 = ~tog6;
      tog2 = ~tog2;
      if (left != 8'h00) left = left - 8'h01;
      if (left == 8'h00 && !fail) busy = 1'b0;
    end else if (busy && in_sect) begin
      // suspended: only the sector toggle keeps moving
      tog2 = ~tog2;
    end
  end
  // data settles a little after the write pulse opens
  always @(posedge wr_w) begin
    #1;
    wd = dq_h;
  end
  // reset command; others dropped once bit 3 set
  always @(negedge wr_w) begin
    if (wd == CMD_RESET_DATA) begin
      busy = 1'b0;
      fail = 1'b0;
      sect = 1'b0;
      timer = 1'b0;
      susp = 1'b0;
      rst_cmds++;
    // an added sector in the open window restarts it
    end else if (busy && !susp && !timer) begin
      left = ld_reads;
    end
  end
endmodule // fsc_flash_model

// ### test/fsc_host_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// pin timing checks on the host side of the flash bus
module fsc_host_asserts
  import fsc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic [19:0] fl_addr,
  input wire logic        fl_dq_oe_n,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // a read and a write strobe together would fight on the data bus
  chk_strobe_excl: assert property (fl_oe_n || fl_we_n)
    else $error("read and write strobes low together");
  chk_oe_drive: assert property (!fl_oe_n |-> fl_dq_oe_n)
    else $error("host drives data during a read");
  chk_write_drive: assert property (!fl_we_n |-> !fl_dq_oe_n)
    else $error("write pulse without data driven");
  chk_ce_cover: assert property ((!fl_oe_n || !fl_we_n) |-> !fl_ce_n)
    else $error("strobe without chip enable");
  chk_read_len: assert property ($fell(fl_oe_n) |->
    !fl_oe_n[*8] ##1 !fl_oe_n[*8] ##1 fl_oe_n)
    else $error("read strobe not sixteen cycles");
  chk_write_len: assert property ($fell(fl_we_n) |->
    !fl_we_n[*7] ##1 fl_we_n)
    else $error("write strobe not seven cycles");
  // recovery gap lets the toggle bits settle between polls
  chk_gap_hold: assert property (($rose(fl_oe_n) || $rose(fl_we_n)) |->
    (fl_oe_n && fl_we_n)[*4])
    else $error("strobe gap shorter than four cycles");
  chk_addr_stable: assert property ((!fl_oe_n && !$past(fl_oe_n)) |->
    $stable(fl_addr))
    else $error("address moved inside a read");
  chk_rd_zero: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data outside its cycle");
  cov_read: cover property ($rose(fl_oe_n));
  cov_write: cover property ($rose(fl_we_n));
  cov_sw_read: cover property (sw_rd ##1 sw_rdata != 32'h0);
endmodule // fsc_host_asserts

// ### test/testbench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module testbench
  import fsc_pkg::*;
;
  logic        clk_sys, rst_n, sw_wr, sw_rd, load, ld_fail, ld_sect, ld_timer;
  logic [3:0]  sw_addr;
  logic [31:0] sw_wdata, sw_rdata, s;
  logic [19:0] fl_addr;
  logic [7:0]  fl_dq_i, fl_dq_o, ld_reads;
  logic        fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, rb;
  logic        clk_en, ld_susp;
  int          rst_cmds, num_errors, samples_checked, n;

  fsc_host u_fsc_host (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .fl_addr(fl_addr), .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .ready_busy_out(rb));
  fsc_flash_model u_fsc_flash_model (.ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .addr(fl_addr), .dq_h(fl_dq_o), .dq_oe_n(fl_dq_oe_n),
    .load(load), .ld_reads(ld_reads), .ld_fail(ld_fail), .ld_sect(ld_sect),
    .ld_timer(ld_timer), .ld_susp(ld_susp), .dq_i(fl_dq_i),
    .ready_busy_out(rb), .rst_cmds(rst_cmds));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      reg_rd(REG_STATUS, s);
      if (s[ST_BUSY] === 1'b0) return;
    end
    num_errors++;
    $display("ERROR t=%0t busy seen=%h exp=%h", $time, s, 32'h0);
    wrap_up();
  endtask
  task automatic set_flash(input logic [7:0] r, input logic f,
                           input logic sc, input logic tm);
    @(posedge clk_sys);
    ld_reads <= r;
    ld_fail <= f;
    ld_sect <= sc;
    ld_timer <= tm;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  task automatic array_read(input logic [19:0] a);
    reg_wr(REG_ADDR, {12'h000, a});
    reg_wr(REG_CTRL, 32'h1 << CTRL_READ);
    wait_idle();
    reg_rd(REG_RDATA, s);
    check(s, {24'h0, a[7:0] ^ 8'h5a});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    array_read(20'h00321);
    reg_rd(4'hf, s);
    check(s, 32'h0);
    // orders given while the clock enable is low must leave no trace
    @(posedge clk_sys);
    clk_en <= 1'b0;
    reg_wr(REG_ADDR, 32'h00055);
    reg_wr(REG_CTRL, 32'h1 << CTRL_READ);
    clk_en <= 1'b1;
    reg_rd(REG_ADDR, s);
    check(s, 32'h00321);
    reg_rd(REG_STATUS, s);
    check(s[ST_BUSY], 1'b0);
    $display("test idle read done");
  endtask
  task automatic t_poll_done();
    reg_wr(REG_ADDR, 32'h10040);
    set_flash(8'h09, 1'b0, 1'b1, 1'b1);
    reg_wr(REG_CTRL, 32'h1 << CTRL_POLL);
    // a second order while busy must be turned away
    reg_wr(REG_CTRL, 32'h1 << CTRL_READ);
    reg_rd(REG_STATUS, s);
    check(s[ST_BUSY], 1'b1);
    check(s[ST_REJECT], 1'b1);
    check(s[ST_READY], 1'b0);
    wait_idle();
    check(s[ST_DONE], 1'b1);
    check(s[ST_FAIL], 1'b0);
    check(s[ST_SUSP], 1'b0);
    check(s[ST_READY], 1'b1);
    reg_rd(REG_RDATA, s);
    check(s, 32'h1a);
    $display("test poll to completion done");
  endtask
  task automatic t_poll_fail();
    n = rst_cmds;
    set_flash(8'h00, 1'b1, 1'b0, 1'b0);
    reg_wr(REG_CTRL, 32'h1 << CTRL_POLL);
    wait_idle();
    check(s[ST_FAIL], 1'b1);
    check(rst_cmds, n + 1);
    reg_rd(REG_STATUS, s);
    check(s[ST_READY], 1'b1);
    reg_rd(REG_RDATA, s);
    check(s[BIT_TIME_LIMIT], 1'b1);
    $display("test poll failure done");
  endtask
  task automatic t_timer();
    set_flash(8'hc8, 1'b0, 1'b1, 1'b0);
    reg_wr(REG_CTRL, 32'h1 << CTRL_ERS_CHECK);
    wait_idle();
    check(s[ST_ERS_TIMER], 1'b0);
    check(s[ST_REJECT], 1'b0);
    set_flash(8'hc8, 1'b0, 1'b1, 1'b1);
    reg_wr(REG_CTRL, 32'h1 << CTRL_ERS_CHECK);
    wait_idle();
    check(s[ST_ERS_TIMER], 1'b1);
    check(s[ST_REJECT], 1'b1);
    n = rst_cmds;
    reg_wr(REG_CTRL, 32'h1 << CTRL_RESET);
    wait_idle();
    check(rst_cmds, n + 1);
    array_read(20'h00abc);
    $display("test erase timer done");
  endtask
  task automatic t_suspend();
    ld_susp <= 1'b1;
    set_flash(8'h00, 1'b0, 1'b1, 1'b0);
    ld_susp <= 1'b0;
    reg_wr(REG_ADDR, 32'h10040);
    reg_wr(REG_CTRL, 32'h1 << CTRL_POLL);
    wait_idle();
    check(s[ST_DONE], 1'b1);
    check(s[ST_SUSP], 1'b1);
    check(s[ST_READY], 1'b1);
    reg_rd(REG_RDATA, s);
    check(s[BIT_POLL], 1'b1);
    array_read(20'h00abc);
    n = rst_cmds;
    reg_wr(REG_CTRL, 32'h1 << CTRL_RESET);
    wait_idle();
    check(rst_cmds, n + 1);
    $display("test erase suspend done");
  endtask
  // reset in the middle of a poll, then the poll starts over
  task automatic t_reset();
    set_flash(8'h20, 1'b0, 1'b0, 1'b0);
    reg_wr(REG_CTRL, 32'h1 << CTRL_POLL);
    repeat (30) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n}, 32'hf);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reg_rd(REG_ADDR, s);
    check(s, 32'h0);
    reg_rd(REG_STATUS, s);
    check(s, 32'h0);
    reg_wr(REG_CTRL, 32'h1 << CTRL_POLL);
    wait_idle();
    check(s[ST_DONE], 1'b1);
    reg_rd(REG_RDATA, s);
    check(s, 32'h5a);
    $display("test reset mid-poll done");
  endtask

  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    {sw_wr, sw_rd, load, ld_fail, ld_sect, ld_timer} = 6'h00;
    clk_en = 1'b1;
    ld_susp = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 32'h0;
    ld_reads = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_idle();
    t_poll_done();
    t_poll_fail();
    t_timer();
    t_suspend();
    t_reset();
    wrap_up();
  end
endmodule // testbench

bind fsc_host fsc_host_asserts u_fsc_host_asserts (.clk_sys(clk_sys),
  .rst_n(rst_n), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .fl_addr(fl_addr),
  .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n));
